//--- inc/mals_pkg.sv
package mals_pkg;

    // ------------------------------------------------------------------
    // register map, byte addresses on the 32-bit bus
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  ADDR_CFG        = 4'h0;
    localparam logic [3:0]  ADDR_CMD        = 4'h4;
    localparam logic [3:0]  ADDR_STATUS     = 4'h8;
    localparam logic [3:0]  ADDR_CAUSE      = 4'hc;

    // ------------------------------------------------------------------
    // configuration fields and reset values
    // ------------------------------------------------------------------
    localparam int          CFG_ADDR_LSB    = 0;
    localparam int          CFG_COUNT_LSB   = 4;
    localparam int          CFG_MODE_LSB    = 8;
    localparam logic [2:0]  RST_STATION     = 3'h0;
    localparam logic [2:0]  RST_SLAVE_COUNT = 3'h1;
    localparam logic [2:0]  RST_MODE        = 3'h0;
    localparam logic [2:0]  MASTER_ADDR     = 3'h0;
    localparam logic [2:0]  MODE_LIMIT      = 3'h3;
    localparam int          CMD_RESET_BIT   = 0;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    localparam int          SYNC_STAGES     = 2;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic link_up;                         // loop frames seen intact
        logic peer_alarm;                      // alarm flagged by another station
        logic peer_reset;                      // batch reset from another station
        logic dup_address;                     // two stations share an address
        logic forward_run_cmd;
        logic reverse_run_cmd;
        logic reset_cmd;                       // terminal or keypad reset
        logic local_fault;                     // heavy fault cause of this unit
        logic light_fault;                     // light fault cause of this unit
        logic speed_pulse_feedback_lost;
        logic motor_thermistor_feedback_lost;
    } mals_pin_in_type;

    typedef struct packed {
        logic link_established_out;
        logic master_selected_out;
        logic run_ready;
        logic run_fwd;
        logic run_rev;
        logic batch_alarm_relay;
        logic coast_stop;
        logic alarm_tx;                        // tell other stations of our alarm
        logic reset_tx;                        // one-cycle batch reset to others
        logic light_alarm;
        logic other_station;                   // shown alarm came from elsewhere
        logic link_error;
        logic proc_error;
    } mals_pin_out_type;

    typedef enum logic [1:0] {
        ST_WAIT_LINK,
        ST_READY,
        ST_RUN,
        ST_ALARM
    } mals_state_type;

endpackage

//--- core/mals_sync.sv
`timescale 1ns/1ps
module mals_sync import mals_pkg::*; #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,     // control clock
    input  wire logic             aresetn,  // synchronous reset, low
    input  wire logic [WIDTH-1:0] d,        // asynchronous levels
    output logic      [WIDTH-1:0] q         // synchronised levels
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule // mals_sync

//--- core/mals_top.sv
`timescale 1ns/1ps
module mals_top import mals_pkg::*; (
    input  wire logic              aclk,      // 100 MHz control clock
    input  wire logic              aresetn,   // synchronous reset, low
    input  wire logic [ADDR_W-1:0] awaddr,    // write address
    input  wire logic              awvalid,   // write address valid
    output logic                   awready,   // write address ready
    input  wire logic [31:0]       wdata,     // write data
    input  wire logic [3:0]        wstrb,     // byte enables
    input  wire logic              wvalid,    // write data valid
    output logic                   wready,    // write data ready
    output logic [1:0]             bresp,     // write response
    output logic                   bvalid,    // write response valid
    input  wire logic              bready,    // write response ready
    input  wire logic [ADDR_W-1:0] araddr,    // read address
    input  wire logic              arvalid,   // read address valid
    output logic                   arready,   // read address ready
    output logic [31:0]            rdata,     // read data
    output logic [1:0]             rresp,     // read response
    output logic                   rvalid,    // read data valid
    input  wire logic              rready,    // read data ready
    input  wire mals_pin_in_type   pins_in,   // pins and link status
    output mals_pin_out_type       pins_out   // supervisory outputs
);
    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    mals_pin_in_type pin_s;
    logic            reset_cmd_d;
    logic            peer_reset_d;
    mals_state_type  state;
    logic            alm_local, alm_fb, alm_link, alm_proc, alm_peer, light;

    mals_sync #(.WIDTH($bits(mals_pin_in_type))) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (pins_in),
        .q       (pin_s)
    );

    // ------------------------------------------------------------------
    // register bus slave
    // ------------------------------------------------------------------
    logic              aw_held, w_held, sw_reset;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic [2:0]        cfg_addr, cfg_count, cfg_mode;
    logic              next_aw_held, next_w_held, next_sw_reset;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [31:0]       next_w_data, next_rdata;
    logic [3:0]        next_w_strb;
    logic [2:0]        next_cfg_addr, next_cfg_count, next_cfg_mode;
    logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]        next_bresp, next_rresp;
    logic              do_write;
    logic [31:0]       cfg_word, status_word, cause_word;

    assign cfg_word    = {21'h0, cfg_mode, 1'b0, cfg_count, 1'b0, cfg_addr};
    assign status_word = {17'h0, state, pins_out};
    assign cause_word  = {26'h0, alm_fb, light, alm_peer, alm_proc, alm_link, alm_local};

    always_comb begin
        next_aw_held   = aw_held;
        next_aw_addr   = aw_addr;
        next_w_held    = w_held;
        next_w_data    = w_data;
        next_w_strb    = w_strb;
        next_bvalid    = bvalid;
        next_bresp     = bresp;
        next_arready   = arready;
        next_rvalid    = rvalid;
        next_rdata     = rdata;
        next_rresp     = rresp;
        next_cfg_addr  = cfg_addr;
        next_cfg_count = cfg_count;
        next_cfg_mode  = cfg_mode;
        next_sw_reset  = 1'b0;
        do_write       = aw_held && w_held && !bvalid;
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            case (aw_addr)
                ADDR_CFG: begin
                    if (w_strb[0]) begin
                        next_cfg_addr  = w_data[CFG_ADDR_LSB+:3];
                        next_cfg_count = w_data[CFG_COUNT_LSB+:3];
                    end
                    if (w_strb[1]) begin
                        next_cfg_mode = w_data[CFG_MODE_LSB+:3];
                    end
                end
                ADDR_CMD:    next_sw_reset = w_strb[0] && w_data[CMD_RESET_BIT];
                ADDR_STATUS: next_bresp = RESP_OKAY;
                ADDR_CAUSE:  next_bresp = RESP_OKAY;
                default:     next_bresp = RESP_SLVERR;
            endcase
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        // ready drops while a word is held so nothing is overwritten
        next_awready = !next_aw_held && !next_bvalid;
        next_wready  = !next_w_held && !next_bvalid;
        if (arvalid && arready) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rresp   = RESP_OKAY;
            case (araddr)
                ADDR_CFG:    next_rdata = cfg_word;
                ADDR_CMD:    next_rdata = 32'h0;
                ADDR_STATUS: next_rdata = status_word;
                ADDR_CAUSE:  next_rdata = cause_word;
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            aw_addr   <= '0;
            w_held    <= 1'b0;
            w_data    <= 32'h0;
            w_strb    <= 4'h0;
            awready   <= 1'b1;
            wready    <= 1'b1;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
            arready   <= 1'b1;
            rvalid    <= 1'b0;
            rdata     <= 32'h0;
            rresp     <= RESP_OKAY;
            cfg_addr  <= RST_STATION;
            cfg_count <= RST_SLAVE_COUNT;
            cfg_mode  <= RST_MODE;
            sw_reset  <= 1'b0;
        end else begin
            aw_held   <= next_aw_held;
            aw_addr   <= next_aw_addr;
            w_held    <= next_w_held;
            w_data    <= next_w_data;
            w_strb    <= next_w_strb;
            awready   <= next_awready;
            wready    <= next_wready;
            bvalid    <= next_bvalid;
            bresp     <= next_bresp;
            arready   <= next_arready;
            rvalid    <= next_rvalid;
            rdata     <= next_rdata;
            rresp     <= next_rresp;
            cfg_addr  <= next_cfg_addr;
            cfg_count <= next_cfg_count;
            cfg_mode  <= next_cfg_mode;
            sw_reset  <= next_sw_reset;
        end
    end

    // ------------------------------------------------------------------
    // alarm latches and run sequencing
    // ------------------------------------------------------------------
    mals_state_type   next_state;
    mals_pin_out_type next_out;
    logic next_alm_local, next_alm_fb, next_alm_link, next_alm_proc, next_alm_peer;
    logic next_light;
    logic is_master, proc_cause, run_req, running, rst_local, rst_req;
    logic set_link, link_cause, fb_cause, own_alarm, any_alarm;

    always_comb begin
        is_master  = (cfg_addr == MASTER_ADDR);
        proc_cause = (cfg_addr > cfg_count) || (cfg_mode >= MODE_LIMIT);
        run_req    = pin_s.forward_run_cmd || pin_s.reverse_run_cmd;
        running    = (state == ST_RUN);
        rst_local  = (pin_s.reset_cmd && !reset_cmd_d) || sw_reset;
        rst_req    = rst_local || (pin_s.peer_reset && !peer_reset_d);
        // loss while stopped is tolerated, so units may power up in any order
        set_link   = running && (!pin_s.link_up || pin_s.dup_address);
        link_cause = !pin_s.link_up || pin_s.dup_address;
        // slaves carry no feedback wiring, so its loss means nothing there
        fb_cause   = is_master && (pin_s.speed_pulse_feedback_lost
                                   || pin_s.motor_thermistor_feedback_lost);
        // set beats clear; clear only once the cause is gone
        next_alm_local = (alm_local && !(rst_req && !pin_s.local_fault))
                         || pin_s.local_fault;
        next_alm_fb    = (alm_fb && !(rst_req && !fb_cause)) || fb_cause;
        next_alm_link  = (alm_link && !(rst_req && !link_cause)) || set_link;
        next_alm_proc  = (alm_proc && !(rst_req && !proc_cause)) || proc_cause;
        next_alm_peer  = (alm_peer && !(rst_req && !pin_s.peer_alarm))
                         || pin_s.peer_alarm;
        next_light     = (light && !(rst_req && !pin_s.light_fault))
                         || pin_s.light_fault;
        own_alarm  = next_alm_local || next_alm_fb || next_alm_link || next_alm_proc;
        any_alarm  = own_alarm || next_alm_peer;

        next_state = state;
        case (state)
            ST_WAIT_LINK: begin
                if (any_alarm)          next_state = ST_ALARM;
                else if (pin_s.link_up) next_state = ST_READY;
            end
            ST_READY: begin
                if (any_alarm)          next_state = ST_ALARM;
                else if (!pin_s.link_up) next_state = ST_WAIT_LINK;
                else if (run_req)       next_state = ST_RUN;
            end
            ST_RUN: begin
                if (any_alarm)          next_state = ST_ALARM;
                else if (!run_req)      next_state = ST_READY;
            end
            ST_ALARM: begin
                // a run command still held after reset restarts the drive
                if (!any_alarm) begin
                    if (!pin_s.link_up) next_state = ST_WAIT_LINK;
                    else if (run_req)   next_state = ST_RUN;
                    else                next_state = ST_READY;
                end
            end
            default: next_state = ST_WAIT_LINK;
        endcase

        next_out.link_established_out = pin_s.link_up;
        next_out.master_selected_out  = is_master;
        next_out.run_ready            = (next_state == ST_READY) || (next_state == ST_RUN);
        next_out.run_fwd = (next_state == ST_RUN) && pin_s.forward_run_cmd
                           && !pin_s.reverse_run_cmd;
        next_out.run_rev = (next_state == ST_RUN) && pin_s.reverse_run_cmd
                           && !pin_s.forward_run_cmd;
        next_out.batch_alarm_relay    = any_alarm;
        next_out.coast_stop           = any_alarm;
        next_out.alarm_tx             = own_alarm;
        next_out.reset_tx             = rst_local;
        next_out.light_alarm          = next_light;
        next_out.other_station        = next_alm_peer && !own_alarm;
        next_out.link_error           = next_alm_link;
        next_out.proc_error           = next_alm_proc;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state        <= ST_WAIT_LINK;
            alm_local    <= 1'b0;
            alm_fb       <= 1'b0;
            alm_link     <= 1'b0;
            alm_proc     <= 1'b0;
            alm_peer     <= 1'b0;
            light        <= 1'b0;
            reset_cmd_d  <= 1'b0;
            peer_reset_d <= 1'b0;
            pins_out     <= '0;
        end else begin
            state        <= next_state;
            alm_local    <= next_alm_local;
            alm_fb       <= next_alm_fb;
            alm_link     <= next_alm_link;
            alm_proc     <= next_alm_proc;
            alm_peer     <= next_alm_peer;
            light        <= next_light;
            reset_cmd_d  <= pin_s.reset_cmd;
            peer_reset_d <= pin_s.peer_reset;
            pins_out     <= next_out;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_running_link_lost;
        (state == ST_RUN) ##0 !pin_s.link_up;
    endsequence
    sequence s_alarm_shown;
        pins_out.batch_alarm_relay && pins_out.coast_stop && !pins_out.run_ready;
    endsequence

    a_no_ready_unlinked: assert property (
        !pin_s.link_up |=> !pins_out.run_ready && !pins_out.run_fwd && !pins_out.run_rev)
        else $error("run ready while link down");
    a_link_status_drop: assert property (
        $fell(pin_s.link_up) |=> !pins_out.link_established_out ##1 !pins_out.run_ready)
        else $error("link status or ready not withdrawn");
    a_peer_alarm_spread: assert property (
        pin_s.peer_alarm |=> s_alarm_shown)
        else $error("peer alarm not spread");
    a_run_break_error: assert property (
        s_running_link_lost |=> pins_out.link_error && pins_out.coast_stop)
        else $error("link break in run not flagged");
    a_stop_no_linkerr: assert property (
        (state != ST_RUN) && !alm_link |=> !alm_link)
        else $error("link error raised while stopped");
    a_own_alarm_sent: assert property (
        pin_s.local_fault |=> pins_out.alarm_tx && pins_out.batch_alarm_relay)
        else $error("own alarm not sent");
    a_other_mark: assert property (
        pin_s.peer_alarm && !alm_local && !alm_fb && !alm_link && !alm_proc
        && !pin_s.local_fault && !proc_cause && !set_link && !fb_cause
        |=> pins_out.other_station)
        else $error("other station mark missing");
    a_link_err_hold: assert property (
        alm_link && link_cause |=> alm_link && pins_out.link_error)
        else $error("link error cleared with cause present");
    a_slave_no_fb: assert property (
        !is_master && !alm_fb |=> !alm_fb)
        else $error("slave raised feedback alarm");
    a_light_local: assert property (
        pins_out.light_alarm && !alm_local && !alm_fb && !alm_link && !alm_proc
        |-> !pins_out.alarm_tx)
        else $error("light alarm sent to link");
    a_light_reset: assert property (
        rst_req && !pin_s.light_fault |=> !light)
        else $error("light alarm survived reset");
    a_master_select: assert property (
        $changed(cfg_addr) |=> pins_out.master_selected_out == (cfg_addr == MASTER_ADDR))
        else $error("master select wrong");
    a_proc_error: assert property (
        cfg_mode >= MODE_LIMIT |=> pins_out.proc_error ##1 pins_out.batch_alarm_relay)
        else $error("procedure error missing");
    a_alarm_latch: assert property (
        alm_local && !rst_req |=> alm_local)
        else $error("alarm cleared without reset");
endmodule // mals_top

//--- test/mals_peer.sv
`timescale 1ns/1ps
module mals_peer import mals_pkg::*; (
    input  wire logic aclk,        // control clock
    input  wire logic link_ok,     // ring intact at the peer side
    input  wire logic fault,       // heavy fault cause at the peer
    input  wire logic rst_req,     // reset given at the peer
    input  wire logic reset_tx,    // batch reset sent by the unit
    output logic      link_up,     // loop status seen by the unit
    output logic      peer_alarm,  // peer shows an alarm
    output logic      peer_reset   // batch reset from the peer
);
    // ------------------------------------------------------------
    // peer station
    // ------------------------------------------------------------
    logic       alarm_q = 1'b0;
    logic       rst_d   = 1'b0;
    logic [2:0] rst_cnt = 3'h0;
    always_ff @(posedge aclk) begin
        rst_d <= rst_req;
        if (fault) begin
            alarm_q <= 1'b1;
        end else if ((rst_req && !rst_d) || reset_tx) begin
            alarm_q <= 1'b0;
        end
        if (rst_req && !rst_d) begin
            rst_cnt <= 3'h5;
        end else if (rst_cnt != 3'h0) begin
            rst_cnt <= rst_cnt - 3'h1;
        end
    end
    // reset goes out two cycles after our own alarm drops, so the cause is gone first
    assign peer_reset = (rst_cnt != 3'h0) && (rst_cnt < 3'h4);
    assign peer_alarm = alarm_q;
    assign link_up    = link_ok;
endmodule // mals_peer

//--- test/tb_mals_top.sv
`timescale 1ns/1ps
module tb_mals_top import mals_pkg::*; ;
    logic             aclk = 1'b0;
    logic             aresetn = 1'b0;
    logic [3:0]       awaddr = 4'h0;
    logic [3:0]       araddr = 4'h0;
    logic [31:0]      wdata = 32'h0;
    logic             awvalid = 1'b0;
    logic             wvalid = 1'b0;
    logic             arvalid = 1'b0;
    logic             awready, wready, bvalid, arready, rvalid;
    logic [1:0]       bresp, rresp;
    logic [31:0]      rdata;
    mals_pin_in_type  drv = '0;
    mals_pin_in_type  pin_w;
    mals_pin_out_type po;
    logic             link_ok = 1'b0;
    logic             fault = 1'b0;
    logic             rst_req = 1'b0;
    logic             link_up, peer_alarm, peer_reset;
    logic [31:0]      cfg_bad [3] = '{32'h12, 32'h15, 32'h310};
    int               err_count = 0;
    int               total_checks = 0;
    int               tx_count = 0;
    // every local reset must leave exactly one pulse towards the other stations
    always @(posedge aclk) begin
        if (po.reset_tx === 1'b1) begin
            tx_count <= tx_count + 1;
        end
    end
    always #5 aclk = ~aclk;
    always_comb begin
        pin_w = drv;
        pin_w.link_up = link_up;
        pin_w.peer_alarm = peer_alarm;
        pin_w.peer_reset = peer_reset;
    end
    mals_top mals_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
        .pins_in(pin_w), .pins_out(po));
    mals_peer mals_peer_i (.aclk(aclk), .link_ok(link_ok), .fault(fault), .rst_req(rst_req),
        .reset_tx(po.reset_tx), .link_up(link_up), .peer_alarm(peer_alarm),
        .peer_reset(peer_reset));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // outputs land three edges after a pin moves, six leaves margin
    task automatic step();
        repeat (6) @(posedge aclk);
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        logic ta;
        logic tw;
        @(posedge aclk);
        ta = 1'b0;
        tw = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (awready && !ta) begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !tw) begin
                tw = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        check(bresp, RESP_OKAY);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        check(rdata, exp);
        check(rresp, RESP_OKAY);
    endtask
    task automatic pulse_rst();
        drv.reset_cmd <= 1'b1;
        repeat (4) @(posedge aclk);
        drv.reset_cmd <= 1'b0;
        step();
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        step();
        check(po.master_selected_out, 1'b1);
        rdchk(ADDR_CFG, 32'h10);
        rdchk(ADDR_STATUS, 32'h800);
        drv.forward_run_cmd <= 1'b1;
        step();
        check({po.run_fwd, po.run_ready, po.link_error}, 3'h0);
        drv.forward_run_cmd <= 1'b0;
        link_ok <= 1'b1;
        step();
        check({po.link_established_out, po.run_ready}, 2'h3);
        drv.forward_run_cmd <= 1'b1;
        step();
        check(po.run_fwd, 1'b1);
        link_ok <= 1'b0;
        step();
        check({po.link_error, po.coast_stop, po.batch_alarm_relay, po.other_station}, 4'he);
        check({po.link_established_out, po.run_ready, po.run_fwd}, 3'h0);
        rdchk(ADDR_CAUSE, 32'h2);
        rdchk(ADDR_STATUS, 32'h68e2);
        pulse_rst();
        check(po.link_error, 1'b1);
        drv.forward_run_cmd <= 1'b0;
        link_ok <= 1'b1;
        step();
        check(po.link_error, 1'b1);
        pulse_rst();
        check({po.link_error, po.batch_alarm_relay}, 2'h0);
        fault <= 1'b1;
        step();
        check({po.batch_alarm_relay, po.other_station, po.coast_stop}, 3'h7);
        fault <= 1'b0;
        step();
        check(po.batch_alarm_relay, 1'b1);
        rst_req <= 1'b1;
        step();
        rst_req <= 1'b0;
        step();
        check(po.batch_alarm_relay, 1'b0);
        drv.local_fault <= 1'b1;
        step();
        check({po.alarm_tx, po.other_station, po.batch_alarm_relay}, 3'h5);
        drv.local_fault <= 1'b0;
        axw(ADDR_CMD, 32'h1);
        step();
        check(po.batch_alarm_relay, 1'b0);
        drv.light_fault <= 1'b1;
        step();
        check({po.light_alarm, po.alarm_tx, po.batch_alarm_relay}, 3'h4);
        drv.light_fault <= 1'b0;
        pulse_rst();
        check(po.light_alarm, 1'b0);
        drv.reverse_run_cmd <= 1'b1;
        step();
        check({po.run_rev, po.run_fwd}, 2'h2);
        drv.forward_run_cmd <= 1'b1;
        step();
        check({po.run_ready, po.run_fwd, po.run_rev}, 3'h4);
        drv.reverse_run_cmd <= 1'b0;
        drv.forward_run_cmd <= 1'b1;
        step();
        drv.dup_address <= 1'b1;
        step();
        check(po.link_error, 1'b1);
        drv.forward_run_cmd <= 1'b0;
        drv.dup_address <= 1'b0;
        step();
        pulse_rst();
        check(po.link_error, 1'b0);
        foreach (cfg_bad[i]) begin
            axw(ADDR_CFG, cfg_bad[i]);
            step();
            check(po.proc_error, 1'b1);
            axw(ADDR_CFG, 32'h10);
            pulse_rst();
            check(po.proc_error, 1'b0);
        end
        axw(ADDR_CFG, 32'h11);
        step();
        check(po.master_selected_out, 1'b0);
        drv.speed_pulse_feedback_lost <= 1'b1;
        drv.motor_thermistor_feedback_lost <= 1'b1;
        step();
        check({po.batch_alarm_relay, po.proc_error}, 2'h0);
        rdchk(ADDR_CFG, 32'h11);
        check(tx_count, 32'h8);
        complete_run();
    end
endmodule // tb_mals_top
